// *** design/nsc_defs.vh ***
// Constants for the NMI, SMI and system control port block.
// Assumes inclusion by bare name from every design file of the block.
`ifndef NSC_DEFS_VH
`define NSC_DEFS_VH

// I/O port addresses (byte wide decode)
`define NSC_PORT_CNT0      8'h40
`define NSC_PORT_CNT1      8'h41
`define NSC_PORT_CNT2      8'h42
`define NSC_PORT_TCTRL     8'h43
`define NSC_PORT_SYSCTL    8'h61
`define NSC_PORT_RTCIDX    8'h70

// System control port field positions
`define NSC_SC_GATE2       0
`define NSC_SC_SPKDATA     1
`define NSC_SC_PAR_DIS     2
`define NSC_SC_CHK_DIS     3
`define NSC_SC_REFRESH     4
`define NSC_SC_OUT2        5
`define NSC_SC_CHK_ST      6
`define NSC_SC_PAR_ST      7

// RTC index port field positions
`define NSC_RI_MASK        7
`define NSC_RI_IDX_W       7

// Reset values and the unmapped read value
`define NSC_SC_RESET       4'h0
`define NSC_MASK_RESET     1'b1
`define NSC_IDX_RESET      7'h00
`define NSC_UNMAPPED_READ  8'hFF

// Timer control word fields
`define NSC_TC_SEL_HI      7
`define NSC_TC_SEL_LO      6
`define NSC_TC_RW_HI       5
`define NSC_TC_RW_LO       4
`define NSC_TC_READBACK    2'b11
`define NSC_RW_LATCH       2'b00
`define NSC_RW_LSB         2'b01
`define NSC_RW_MSB         2'b10
`define NSC_RW_BOTH        2'b11
`define NSC_MODE0          3'h0
`define NSC_MODE2          3'h2
`define NSC_MODE3          3'h3

// Timer input clock derived from the core clock
`define NSC_CORE_CLK_HZ    125000000
`define NSC_TMR_CLK_HZ     1193000
`define NSC_TMR_DIV        (`NSC_CORE_CLK_HZ / `NSC_TMR_CLK_HZ)
`define NSC_DIV_W          7

`endif

// *** design/nsc_counter.v ***
// One down counter of the three-counter interval timer.
// Assumes a one-cycle tick at the timer input rate and single-cycle
// write and read strobes from the enclosing port decoder.
`timescale 1ns/1ps
`include "nsc_defs.vh"

module nsc_counter (
    input  wire       core_clk,
    input  wire       reset,
    input  wire       tick,
    input  wire       gate,
    input  wire       ctrl_we,
    input  wire [5:0] ctrl_data,
    input  wire       wr_en,
    input  wire [7:0] wr_data,
    input  wire       rd_en,
    output wire [7:0] rd_data,
    output reg        out_r
);

    reg [15:0] count_r;
    reg [15:0] reload_r;
    reg [15:0] latch_r;
    reg        latched_r;
    reg [1:0]  rw_r;
    reg [2:0]  mode_r;
    reg        wr_hi_r;
    reg        rd_hi_r;
    reg        load_pend_r;

    wire [15:0] view = latched_r ? latch_r : count_r;
    wire        rd_sel_hi = (rw_r == `NSC_RW_MSB) || (rw_r == `NSC_RW_BOTH && rd_hi_r);

    // Byte selected by the access mode and the read flip-flop
    assign rd_data = rd_sel_hi ? view[15:8] : view[7:0];

    // Programming, counting and output shaping
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            count_r     <= 16'h0000;
            reload_r    <= 16'h0000;
            latch_r     <= 16'h0000;
            latched_r   <= 1'b0;
            rw_r        <= `NSC_RW_BOTH;
            mode_r      <= `NSC_MODE0;
            wr_hi_r     <= 1'b0;
            rd_hi_r     <= 1'b0;
            load_pend_r <= 1'b0;
            out_r       <= 1'b0;
        end else begin
            if (ctrl_we) begin
                if (ctrl_data[5:4] == `NSC_RW_LATCH) begin
                    // Latch command freezes the view until fully read
                    if (!latched_r) begin
                        latch_r   <= count_r;
                        latched_r <= 1'b1;
                    end
                end else begin
                    rw_r        <= ctrl_data[5:4];
                    mode_r      <= ctrl_data[3:1];
                    wr_hi_r     <= 1'b0;
                    rd_hi_r     <= 1'b0;
                    load_pend_r <= 1'b0;
                    out_r       <= (ctrl_data[3:1] != `NSC_MODE0);
                end
            end else if (wr_en) begin
                case (rw_r)
                    `NSC_RW_LSB: begin
                        reload_r    <= {8'h00, wr_data};
                        load_pend_r <= 1'b1;
                    end
                    `NSC_RW_MSB: begin
                        reload_r    <= {wr_data, 8'h00};
                        load_pend_r <= 1'b1;
                    end
                    default: begin
                        // Low byte first; the count only loads after the high byte
                        if (wr_hi_r) begin
                            reload_r[15:8] <= wr_data;
                            load_pend_r    <= 1'b1;
                        end else begin
                            reload_r[7:0] <= wr_data;
                        end
                        wr_hi_r <= ~wr_hi_r;
                    end
                endcase
                if (mode_r == `NSC_MODE0) begin
                    out_r <= 1'b0;
                end
            end else if (tick) begin
                if (load_pend_r) begin
                    count_r     <= reload_r;
                    load_pend_r <= 1'b0;
                end else if (!gate) begin
                    // Gate low holds the count; rate modes idle high
                    if (mode_r != `NSC_MODE0) begin
                        out_r <= 1'b1;
                    end
                end else begin
                    case (mode_r)
                        `NSC_MODE2: begin
                            if (count_r == 16'h0002) begin
                                out_r   <= 1'b0;
                                count_r <= count_r - 16'h0001;
                            end else if (count_r == 16'h0001) begin
                                out_r   <= 1'b1;
                                count_r <= reload_r;
                            end else begin
                                count_r <= count_r - 16'h0001;
                            end
                        end
                        `NSC_MODE3: begin
                            // Steps of two; odd reloads drift half a tick
                            if (count_r == 16'h0002 || count_r == 16'h0001) begin
                                out_r   <= ~out_r;
                                count_r <= reload_r;
                            end else begin
                                count_r <= count_r - 16'h0002;
                            end
                        end
                        default: begin
                            if (count_r == 16'h0001) begin
                                out_r <= 1'b1;
                            end
                            count_r <= count_r - 16'h0001;
                        end
                    endcase
                end
            end
            // Read side byte pointer and latch release
            if (rd_en && !ctrl_we) begin
                if (rw_r == `NSC_RW_BOTH) begin
                    rd_hi_r <= ~rd_hi_r;
                    if (rd_hi_r) begin
                        latched_r <= 1'b0;
                    end
                end else begin
                    latched_r <= 1'b0;
                end
            end
        end
    end

endmodule

// *** design/nsc_sysctl.v ***
// NMI and SMI generation, system control port and interval timer.
// Assumes a byte-wide I/O strobe interface synchronous to core_clk,
// with at most one of io_wr and io_rd high in a cycle.
`timescale 1ns/1ps
`include "nsc_defs.vh"

module nsc_sysctl (
    input  wire                    core_clk,
    input  wire                    reset,
    input  wire [7:0]              io_addr,
    input  wire                    io_wr,
    input  wire                    io_rd,
    input  wire [7:0]              io_wdata,
    output reg  [7:0]              io_rdata_r,
    input  wire                    iochk_n,
    input  wire                    pci_perr,
    input  wire                    pm_enable,
    input  wire                    inact_expired,
    input  wire                    kbd_lock_req,
    input  wire                    smi_done,
    output reg                     nmi_n_r,
    output reg                     smi_n_r,
    output reg                     irq0_r,
    output reg                     refresh_req_r,
    output reg                     speaker_r,
    output reg  [`NSC_RI_IDX_W-1:0] rtc_index_r
);

    // Port decode used for both read and write steering
    function is_port;
        input [7:0] addr;
        input [7:0] port;
        begin
            is_port = (addr == port);
        end
    endfunction

    reg [`NSC_DIV_W-1:0] div_r;
    reg                  tick_r;
    reg [3:0]            sc_ctl_r;
    reg                  nmi_mask_r;
    reg                  par_st_r;
    reg                  refresh_tgl_r;
    reg                  out1_d_r;
    reg                  smi_pend_r;

    wire [2:0] cnt_out;
    wire [7:0] cnt_rd [0:2];
    wire [2:0] cnt_gate;
    wire       chk_st;
    wire       nmi_req;
    wire       smi_set;
    wire       tctrl_wr;

    // Timer input tick from the core clock; integer divide trades a small
    // rate error for a plain counter
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            div_r  <= {`NSC_DIV_W{1'b0}};
            tick_r <= 1'b0;
        end else if (div_r == `NSC_TMR_DIV - 1) begin
            div_r  <= {`NSC_DIV_W{1'b0}};
            tick_r <= 1'b1;
        end else begin
            div_r  <= div_r + {{(`NSC_DIV_W-1){1'b0}}, 1'b1};
            tick_r <= 1'b0;
        end
    end

    // fixed gating
    // Counters 0 and 1 always run; counter 2 follows the port gate
    // counter 2 gate
    assign cnt_gate = {sc_ctl_r[`NSC_SC_GATE2], 1'b1, 1'b1};
    assign tctrl_wr = io_wr && is_port(io_addr, `NSC_PORT_TCTRL);

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_cnt
            nsc_counter u_cnt (
                .core_clk  (core_clk),
                .reset     (reset),
                .tick      (tick_r),
                .gate      (cnt_gate[gi]),
                .ctrl_we   (tctrl_wr &&
                            io_wdata[`NSC_TC_SEL_HI:`NSC_TC_SEL_LO] == gi[1:0] &&
                            io_wdata[`NSC_TC_SEL_HI:`NSC_TC_SEL_LO] != `NSC_TC_READBACK),
                .ctrl_data (io_wdata[5:0]),
                .wr_en     (io_wr && is_port(io_addr, `NSC_PORT_CNT0 + gi[7:0])),
                .wr_data   (io_wdata),
                .rd_en     (io_rd && is_port(io_addr, `NSC_PORT_CNT0 + gi[7:0])),
                .rd_data   (cnt_rd[gi]),
                .out_r     (cnt_out[gi])
            );
        end
    endgenerate

    // channel check status
    // Level status, forced low while the source is disabled
    assign chk_st = ~iochk_n & ~sc_ctl_r[`NSC_SC_CHK_DIS];

    // Control bits, global mask and RTC index writes
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sc_ctl_r    <= `NSC_SC_RESET;
            nmi_mask_r  <= `NSC_MASK_RESET;
            rtc_index_r <= `NSC_IDX_RESET;
        end else if (io_wr) begin
            if (is_port(io_addr, `NSC_PORT_SYSCTL)) begin
                sc_ctl_r <= io_wdata[3:0];
            end
            if (is_port(io_addr, `NSC_PORT_RTCIDX)) begin
                nmi_mask_r  <= io_wdata[`NSC_RI_MASK];
                rtc_index_r <= io_wdata[`NSC_RI_IDX_W-1:0];
            end
        end
    end

    // parity status cleared
    // Disable bit holds the status clear; it wins over a new error since
    // a disabled source must not be remembered across re-enable
    // parity error capture
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            par_st_r <= 1'b0;
        end else if (sc_ctl_r[`NSC_SC_PAR_DIS]) begin
            par_st_r <= 1'b0;
        end else if (pci_perr) begin
            par_st_r <= 1'b1;
        end
    end

    // refresh toggle
    // Each rising edge of counter 1 is one refresh request
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            out1_d_r      <= 1'b0;
            refresh_tgl_r <= 1'b0;
            refresh_req_r <= 1'b0;
        end else begin
            out1_d_r      <= cnt_out[1];
            refresh_req_r <= cnt_out[1] & ~out1_d_r;
            if (cnt_out[1] & ~out1_d_r) begin
                refresh_tgl_r <= ~refresh_tgl_r;
            end
        end
    end

    assign smi_set = (pm_enable & inact_expired) | kbd_lock_req;

    // SMI pending until the handler signals completion; a new cause in
    // the completion cycle keeps it pending
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            smi_pend_r <= 1'b0;
        end else if (smi_set) begin
            smi_pend_r <= 1'b1;
        end else if (smi_done) begin
            smi_pend_r <= 1'b0;
        end
    end

    assign nmi_req = (par_st_r | chk_st) & ~nmi_mask_r;

    // Interrupt and timer outputs, all registered
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            nmi_n_r   <= 1'b1;
            smi_n_r   <= 1'b1;
            irq0_r    <= 1'b0;
            speaker_r <= 1'b0;
        end else begin
            nmi_n_r   <= ~(nmi_req & ~smi_pend_r & ~smi_set);
            smi_n_r   <= ~(smi_pend_r | smi_set);
            irq0_r    <= cnt_out[0];
            speaker_r <= cnt_out[2] & sc_ctl_r[`NSC_SC_SPKDATA];
        end
    end

    // Read data, registered one cycle after the strobe; write-only and
    // unmapped ports float high as on an idle data bus
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            io_rdata_r <= 8'h00;
        end else if (io_rd) begin
            case (io_addr)
                `NSC_PORT_CNT0: io_rdata_r <= cnt_rd[0];
                `NSC_PORT_CNT1: io_rdata_r <= cnt_rd[1];
                `NSC_PORT_CNT2: io_rdata_r <= cnt_rd[2];
                `NSC_PORT_SYSCTL: begin
                    io_rdata_r <= {par_st_r, chk_st, cnt_out[2], refresh_tgl_r, sc_ctl_r};
                end
                default: io_rdata_r <= `NSC_UNMAPPED_READ;
            endcase
        end
    end

endmodule

// *** testbench/nsc_sysctl_props.sv ***
// Checker for the NMI, SMI and system control port block.
// Assumes binding onto nsc_sysctl; sees only its ports.
`timescale 1ns/1ps
module nsc_sysctl_props (
    input wire       core_clk,
    input wire       reset,
    input wire [7:0] io_addr,
    input wire       io_wr,
    input wire       io_rd,
    input wire [7:0] io_wdata,
    input wire [7:0] io_rdata_r,
    input wire       iochk_n,
    input wire       pci_perr,
    input wire       pm_enable,
    input wire       inact_expired,
    input wire       kbd_lock_req,
    input wire       smi_done,
    input wire       nmi_n_r,
    input wire       smi_n_r,
    input wire       irq0_r,
    input wire       refresh_req_r,
    input wire       speaker_r,
    input wire [6:0] rtc_index_r
);
    reg  [3:0] ctl_r;
    reg        mask_r;
    wire       cause = kbd_lock_req | (pm_enable & inact_expired);
    wire       rd_ok = (io_addr[7:2] == 6'h10 && io_addr[1:0] != 2'h3) || io_addr == 8'h61;
    // Shadow of writable bits, so checks need no internal probes
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctl_r  <= 4'h0;
            mask_r <= 1'b1;
        end else if (io_wr && io_addr == 8'h61) begin
            ctl_r <= io_wdata[3:0];
        end else if (io_wr && io_addr == 8'h70) begin
            mask_r <= io_wdata[7];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_chk_live;
        !iochk_n && !ctl_r[3] && !mask_r && smi_n_r && !cause;
    endsequence
    sequence s_all_off;
        ctl_r[2] && (ctl_r[3] || iochk_n);
    endsequence
    property p_chk_nmi; s_chk_live [*3] |-> !nmi_n_r; endproperty
    a_chk_nmi: assert property (p_chk_nmi) else $error("nmi missing");
    property p_mask; mask_r [*3] |-> nmi_n_r; endproperty
    a_mask: assert property (p_mask) else $error("nmi while masked");
    property p_srcs_off; s_all_off [*3] |-> nmi_n_r; endproperty
    a_srcs_off: assert property (p_srcs_off) else $error("nmi from disabled");
    property p_smi_first; !smi_n_r [*2] |-> nmi_n_r; endproperty
    a_smi_first: assert property (p_smi_first) else $error("nmi during smi");
    property p_kbd; kbd_lock_req |-> ##[1:2] !smi_n_r; endproperty
    a_kbd: assert property (p_kbd) else $error("no smi on lock");
    property p_inact; pm_enable && inact_expired |-> ##[1:2] !smi_n_r; endproperty
    a_inact: assert property (p_inact) else $error("no smi on expiry");
    property p_no_cause; smi_n_r && !cause |=> smi_n_r; endproperty
    a_no_cause: assert property (p_no_cause) else $error("smi without cause");
    property p_smi_end; !smi_n_r && smi_done && !cause |-> ##[1:2] smi_n_r; endproperty
    a_smi_end: assert property (p_smi_end) else $error("smi not released");
    property p_rd_ctl; io_rd && io_addr == 8'h61 |=> io_rdata_r[3:0] == $past(ctl_r); endproperty
    a_rd_ctl: assert property (p_rd_ctl) else $error("control bits wrong");
    property p_rd_ff; io_rd && !rd_ok |=> io_rdata_r == 8'hFF; endproperty
    a_rd_ff: assert property (p_rd_ff) else $error("bad unmapped read");
    property p_rd_hold; !io_rd |=> $stable(io_rdata_r); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_refresh; refresh_req_r |=> !refresh_req_r; endproperty
    a_refresh: assert property (p_refresh) else $error("refresh pulse long");
    property p_spk; !ctl_r[1] [*2] |-> !speaker_r; endproperty
    a_spk: assert property (p_spk) else $error("speaker while off");
    property p_idx;
        io_wr && io_addr == 8'h70 |=> {1'b0, rtc_index_r} == ($past(io_wdata) & 8'h7F);
    endproperty
    a_idx: assert property (p_idx) else $error("index bits lost");
endmodule
bind nsc_sysctl nsc_sysctl_props props_u (.*);

// *** testbench/nsc_host_model.sv ***
// Host core model: takes NMI and SMI, ends each SMI after dly clocks.
// Assumes the bench sets dly; acts on falling edges like the bench.
`timescale 1ns/1ps
module nsc_host_model (
    input  wire       core_clk,
    input  wire       reset,
    input  wire       nmi_n_r,
    input  wire       smi_n_r,
    input  wire [3:0] dly,
    output reg        smi_done
);
    reg     [3:0] wait_r = 4'h0;
    reg           smi_q_r = 1'b1;
    integer       n_smi = 0;
    always @(negedge core_clk or posedge reset) begin
        if (reset) begin
            smi_done <= 1'b0;
            wait_r   <= 4'h0;
        end else begin
            smi_done <= 1'b0;
            smi_q_r  <= smi_n_r;
            if (!smi_n_r && smi_q_r)
                n_smi <= n_smi + 1;
            if (!smi_n_r && !smi_done) begin
                wait_r <= wait_r + 4'h1;
                if (wait_r == dly) begin
                    smi_done <= 1'b1;
                    wait_r   <= 4'h0;
                end
            end
        end
    end
endmodule

// *** testbench/nmi_smi_system_control_port_tb.sv ***
// Testbench for the NMI, SMI and system control port block.
// Assumes a timer tick every 104 clocks and the host model for SMI.
`timescale 1ns/1ps
module nmi_smi_system_control_port_tb;
    reg        core_clk;
    reg        reset = 1'b1;
    reg  [7:0] io_addr = 8'h00;
    reg        io_wr = 1'b0;
    reg        io_rd = 1'b0;
    reg  [7:0] io_wdata = 8'h00;
    reg        iochk_n = 1'b1;
    reg        pci_perr = 1'b0;
    reg        pm_enable = 1'b0;
    reg        inact_expired = 1'b0;
    reg        kbd_lock_req = 1'b0;
    reg  [3:0] dly = 4'h6;
    wire       smi_done;
    wire [7:0] io_rdata_r;
    wire       nmi_n_r, smi_n_r, irq0_r, refresh_req_r, speaker_r;
    wire [6:0] rtc_index_r;
    reg  [7:0] d, d0;
    reg        cnt_en = 1'b0;
    integer    n_fail = 0, checked = 0, cyc = 0, i;
    integer    n_ref = 0, n_irq = 0, n_spk = 0;
    nsc_sysctl dut_u (.*);
    nsc_host_model host_u (.*);
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Edge counters for timer outputs, only inside a window
    // Refresh pulses sampled on the clock, so the window lines up with port reads
    always @(posedge core_clk) if (cnt_en && refresh_req_r) n_ref = n_ref + 1;
    always @(posedge irq0_r) if (cnt_en) n_irq = n_irq + 1;
    always @(posedge speaker_r) if (cnt_en) n_spk = n_spk + 1;
    // Hang guard, well above the expected run length
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            n_fail = n_fail + 1;
            end_of_test;
        end
    end
    task end_of_test;
        begin
            $display("checks %0d fails %0d", checked, n_fail);
            if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task chk(input string nm, input [7:0] seen, input [7:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("BAD %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task chkb(input string nm, input seen, input exp);
        chk(nm, {7'h00, seen}, {7'h00, exp});
    endtask
    task cy(input integer n);
        repeat (n) @(negedge core_clk);
    endtask
    task wr(input [7:0] a, input [7:0] v);
        begin
            @(negedge core_clk);
            io_addr = a;
            io_wdata = v;
            io_wr = 1'b1;
            @(negedge core_clk);
            io_wr = 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(negedge core_clk);
            io_addr = a;
            io_rd = 1'b1;
            @(negedge core_clk);
            io_rd = 1'b0;
            d = io_rdata_r;
        end
    endtask
    task perr_pulse;
        begin
            @(negedge core_clk);
            pci_perr = 1'b1;
            @(negedge core_clk);
            pci_perr = 1'b0;
        end
    endtask
    task wait_smi;
        for (i = 0; i < 40 && smi_n_r !== 1'b1; i = i + 1) @(negedge core_clk);
    endtask
    task t_reset;
        begin
            rd(8'h61);
            chk("port61", d & 8'hEF, 8'h00);
            wr(8'h55, 8'hFF);
            rd(8'h55);
            chk("unmapped", d, 8'hFF);
            rd(8'h43);
            chk("ctrlword", d, 8'hFF);
            $display("test reset done");
        end
    endtask
    task t_parity;
        begin
            perr_pulse;
            cy(3);
            chkb("nmi_masked", nmi_n_r, 1'b1);
            rd(8'h61);
            chkb("par_st", d[7], 1'b1);
            wr(8'h70, 8'h00);
            cy(3);
            chkb("nmi_par", nmi_n_r, 1'b0);
            wr(8'h61, 8'h04);
            cy(3);
            chkb("nmi_clr", nmi_n_r, 1'b1);
            perr_pulse;
            rd(8'h61);
            chk("par_dis", d & 8'h8F, 8'h04);
            wr(8'h61, 8'h00);
            cy(3);
            chkb("nmi_idle", nmi_n_r, 1'b1);
            $display("test parity done");
        end
    endtask
    task t_chk;
        begin
            @(negedge core_clk) iochk_n = 1'b0;
            cy(3);
            chkb("nmi_chk", nmi_n_r, 1'b0);
            rd(8'h61);
            chkb("chk_st", d[6], 1'b1);
            wr(8'h70, 8'h8D);
            cy(3);
            chkb("nmi_mask", nmi_n_r, 1'b1);
            chk("index", {1'b0, rtc_index_r}, 8'h0D);
            wr(8'h70, 8'h0D);
            wr(8'h61, 8'h08);
            cy(3);
            chkb("nmi_chkdis", nmi_n_r, 1'b1);
            rd(8'h61);
            chkb("chk_clr", d[6], 1'b0);
            wr(8'h61, 8'h00);
            cy(3);
            chkb("nmi_again", nmi_n_r, 1'b0);
            $display("test channel check done");
        end
    endtask
    task t_smi;
        begin
            @(negedge core_clk) kbd_lock_req = 1'b1;
            @(negedge core_clk) kbd_lock_req = 1'b0;
            cy(1);
            chkb("smi_lock", smi_n_r, 1'b0);
            chkb("nmi_held", nmi_n_r, 1'b1);
            wait_smi;
            cy(3);
            chkb("nmi_back", nmi_n_r, 1'b0);
            @(negedge core_clk) inact_expired = 1'b1;
            cy(2);
            inact_expired = 1'b0;
            cy(3);
            chkb("smi_pm_off", smi_n_r, 1'b1);
            dly = 4'h0;
            pm_enable = 1'b1;
            @(negedge core_clk) inact_expired = 1'b1;
            @(negedge core_clk) inact_expired = 1'b0;
            wait_smi;
            chkb("smi_end", smi_n_r, 1'b1);
            chk("smi_count", host_u.n_smi[7:0], 8'h02);
            iochk_n = 1'b1;
            cy(3);
            chkb("nmi_off", nmi_n_r, 1'b1);
            $display("test smi done");
        end
    endtask
    task t_timer;
        begin
            wr(8'h43, 8'h54);
            wr(8'h41, 8'h02);
            wr(8'h43, 8'h16);
            wr(8'h40, 8'h04);
            cy(208);
            rd(8'h61);
            d0 = d;
            cnt_en = 1'b1;
            cy(2080);
            rd(8'h61);
            cnt_en = 1'b0;
            chkb("refresh_n", n_ref >= 9 && n_ref <= 11, 1'b1);
            chkb("refresh_tgl", d[4], d0[4] ^ n_ref[0]);
            chkb("irq0_n", n_irq >= 4 && n_irq <= 6, 1'b1);
            rd(8'h41);
            chkb("cnt1_rd", d == 8'h01 || d == 8'h02, 1'b1);
            wr(8'h43, 8'h40);
            rd(8'h41);
            chkb("cnt1_latch", d == 8'h01 || d == 8'h02, 1'b1);
            wr(8'h43, 8'hB6);
            wr(8'h42, 8'h04);
            wr(8'h42, 8'h00);
            wr(8'h61, 8'h03);
            cy(208);
            cnt_en = 1'b1;
            cy(2080);
            cnt_en = 1'b0;
            chkb("spk_n", n_spk >= 4 && n_spk <= 6, 1'b1);
            wr(8'h61, 8'h02);
            cy(416);
            n_spk = 0;
            cnt_en = 1'b1;
            cy(1040);
            cnt_en = 1'b0;
            chkb("spk_stop", n_spk == 0, 1'b1);
            rd(8'h61);
            chkb("out2_hi", d[5], 1'b1);
            wr(8'h61, 8'h00);
            cy(3);
            chkb("spk_off", speaker_r, 1'b0);
            $display("test timer done");
        end
    endtask
    initial begin
        repeat (3) @(negedge core_clk);
        reset = 1'b0;
        t_reset;
        t_parity;
        t_chk;
        t_smi;
        t_timer;
        end_of_test;
    end
endmodule
